/* hdl/rzf_reserved_zero_field.sv */
// reserved-zero field storage and read-back for one register
// Notes on behaviour
// - a hardwired reserved bit always reads as zero.
// - write data aimed at a hardwired reserved bit is thrown away.
// - an indirect write clears a writable reserved bit to zero.
// - a writable reserved bit reads back its last successful write.
// - before any write a writable reserved bit reads its reset value.
// - a direct write updates the storage behind a writable bit.
// - stored reserved values, by the previous cycle's context, never reach the core's working view.
// - each field picks hardwired or writable form on its own.
// - a context-reserved bit is cleared by an indirect write there.
// - a context-reserved bit keeps its value across contexts.
`timescale 1ns/1ps
`include "rzf_cfg.svh"

module rzf_reserved_zero_field
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 wr_strobe_in,
   input  wire logic                 wr_direct_in,
   input  wire rzf_pkg::rzf_field_t  wr_data_in,
   input  wire logic                 rd_strobe_in,
   input  wire logic                 ctx_reserved_in,
   output logic                      rd_valid_out,
   output rzf_pkg::rzf_field_t       rd_data_out,
   output rzf_pkg::rzf_field_t       core_field_out
);

   // ********************************************************************
   // helpers
   // ********************************************************************

   // bits that are reserved under the given context
   function automatic rzf_pkg::rzf_field_t reserved_mask
   (
      input logic ctx
   );
      reserved_mask = ctx ? (`RZF_ALWAYS_MASK | `RZF_CTX_MASK)
                          : `RZF_ALWAYS_MASK;
   endfunction : reserved_mask

   // ********************************************************************
   // storage behind the writable bits
   // ********************************************************************

   rzf_pkg::rzf_field_t   store_q;
   rzf_pkg::rzf_field_t   store_d;
   rzf_pkg::rzf_wr_kind_t wr_kind;
   rzf_pkg::rzf_field_t   clear_mask;

   // direct/indirect flag from the port, typed for clarity
   assign wr_kind = rzf_pkg::rzf_wr_kind_t'(wr_direct_in);

   // next stored value; only stored bits ever load, so hardwired ones
   // only ever hold zero in store_q and no write can leave a trace there
   always_comb
   begin
      clear_mask = reserved_mask(ctx_reserved_in);
      store_d    = store_q;
      if (wr_strobe_in)
      begin
         case (wr_kind)
            rzf_pkg::RZF_WR_DIRECT:
            begin
               // direct write loads every stored bit
               store_d = wr_data_in & `RZF_STORED_MASK;
            end
            rzf_pkg::RZF_WR_INDIRECT:
            begin
               // reserved bits go to zero, defined ones take the data
               store_d = wr_data_in & `RZF_STORED_MASK
                         & ~clear_mask;
            end
            default:
            begin
               store_d = store_q;
            end
         endcase
      end
      store_d = store_d & ~`RZF_HARDWIRED_MASK;
   end

   // register the storage; no write means the value simply holds,
   // whichever context the register is used in
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
         store_q <= `RZF_RESET_VAL & `RZF_STORED_MASK;
      else
         store_q <= store_d;
   end

   // ********************************************************************
   // read port and core view
   // ********************************************************************

   logic                rd_valid_d;
   rzf_pkg::rzf_field_t rd_data_d;
   rzf_pkg::rzf_field_t core_field_d;

   // read returns stored bits as held before any same-cycle write;
   // the core sees only bits that are defined in the current cycle's context
   always_comb
   begin
      rd_valid_d   = rd_strobe_in;
      rd_data_d    = `RZF_ZERO;
      if (rd_strobe_in)
         rd_data_d = store_q & ~`RZF_HARDWIRED_MASK;
      core_field_d = store_d & ~reserved_mask(ctx_reserved_in)
                     & ~`RZF_HARDWIRED_MASK;
   end

   // outputs straight from flops
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         rd_valid_out   <= 1'b0;
         rd_data_out    <= `RZF_ZERO;
         core_field_out <= `RZF_ZERO;
      end
      else
      begin
         rd_valid_out   <= rd_valid_d;
         rd_data_out    <= rd_data_d;
         core_field_out <= core_field_d;
      end
   end

   // ********************************************************************
   // checks
   // ********************************************************************

   default clocking chk_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // the hardwired nibble neither reads back nor keeps anything
   hardwired_read_zero_a: assert property (
      rd_valid_out |-> ((rd_data_out & `RZF_HARDWIRED_MASK) == `RZF_ZERO))
      else $error("hardwired bit read as nonzero");

   hardwired_no_store_a: assert property (
      wr_strobe_in |=> ((store_q & `RZF_HARDWIRED_MASK) == `RZF_ZERO))
      else $error("hardwired bit took write data");

   // indirect writes clear whatever is reserved in the context of the
   // write; bits 7:6 only count as reserved while the context says so
   indirect_clear_a: assert property (
      (wr_strobe_in && !wr_direct_in && !ctx_reserved_in)
      |=> ((store_q & `RZF_ALWAYS_MASK) == `RZF_ZERO))
      else $error("indirect write left reserved bit set");

   ctx_clear_a: assert property (
      (wr_strobe_in && !wr_direct_in && ctx_reserved_in)
      |=> ((store_q & (`RZF_ALWAYS_MASK | `RZF_CTX_MASK)) == `RZF_ZERO))
      else $error("indirect write left context bit set");

   // direct write, then a read in the very next cycle with no write
   // between: the read must hand back the stored part of the data
   read_last_write_a: assert property (
      (wr_strobe_in && wr_direct_in) ##1 (rd_strobe_in && !wr_strobe_in)
      |=> (rd_data_out == ($past(wr_data_in, 2) & `RZF_STORED_MASK)))
      else $error("read did not return last written value");

   // only a read in the first cycle out of reset is tied to the reset
   // value here; a later read is checked in full only by read_last_write_a, right after a direct write
   reset_value_a: assert property (
      ($past(!rst_n_in) && rd_strobe_in) |=>
      (rd_data_out == (`RZF_RESET_VAL & `RZF_STORED_MASK)))
      else $error("first read after reset not reset value");

   direct_update_a: assert property (
      (wr_strobe_in && wr_direct_in) |=>
      (store_q == ($past(wr_data_in) & `RZF_STORED_MASK)))
      else $error("direct write did not update storage");

   // the core view is registered, so it answers to the context of the
   // cycle before
   core_isolated_a: assert property (
      1'b1 |=> ((core_field_out & reserved_mask($past(ctx_reserved_in)))
                == `RZF_ZERO))
      else $error("reserved value reached the core view");

   // a context swap on its own leaves the storage untouched
   ctx_hold_a: assert property (
      (!wr_strobe_in && $changed(ctx_reserved_in)) |=> $stable(store_q))
      else $error("context change disturbed stored value");

   // every read gets exactly one answer one cycle later, none unasked
   read_answer_a: assert property (
      rd_strobe_in |=> rd_valid_out)
      else $error("read answer missing");

   read_unasked_a: assert property (
      !rd_strobe_in |=> !rd_valid_out)
      else $error("read answer without request");

   // data lines rest at zero between answers so stale values never leak
   idle_data_zero_a: assert property (
      !rd_valid_out |-> (rd_data_out == `RZF_ZERO))
      else $error("read data not zero while idle");

   // main scenarios the bench is expected to reach
   cover_reset_read_c: cover property (
      $past(!rst_n_in) && rd_strobe_in);

   cover_direct_then_read_c: cover property (
      (wr_strobe_in && wr_direct_in) ##1 rd_strobe_in);

   cover_indirect_ctx_c: cover property (
      wr_strobe_in && !wr_direct_in && ctx_reserved_in);

   cover_ctx_swap_read_c: cover property (
      (wr_strobe_in && wr_direct_in && !ctx_reserved_in)
      ##2 ctx_reserved_in ##1 rd_strobe_in);

   cover_write_read_same_c: cover property (
      wr_strobe_in && rd_strobe_in);

endmodule : rzf_reserved_zero_field

/* include/rzf_cfg.svh */
// constants for the reserved-zero field logic
`ifndef RZF_CFG_SVH
`define RZF_CFG_SVH

// ********************************************************************
// field geometry
// ********************************************************************
`define RZF_WIDTH          8
// bits built in the hardwired form: read zero, writes discarded
`define RZF_HARDWIRED_MASK 8'h0f
// bits built in the writable form, reserved in every context
`define RZF_ALWAYS_MASK    8'h30
// writable bits that are reserved only while the context says so
`define RZF_CTX_MASK       8'hc0
// all bits with storage behind them
`define RZF_STORED_MASK    8'hf0

// ********************************************************************
// reset values
// ********************************************************************
`define RZF_RESET_VAL      8'ha0
`define RZF_ZERO           8'h00

`endif

/* include/rzf_pkg.sv */
// types shared by the reserved-zero field logic
`include "rzf_cfg.svh"

package rzf_pkg;

   // one register's worth of field bits
   typedef logic [`RZF_WIDTH-1:0] rzf_field_t;

   // kind of write presented by the register port
   typedef enum logic
   {
      RZF_WR_INDIRECT = 1'b0,
      RZF_WR_DIRECT   = 1'b1
   } rzf_wr_kind_t;

endpackage : rzf_pkg

/* tb/tb.sv */
// self-checking testbench for the reserved-zero field logic
`timescale 1ns/1ps
`include "rzf_cfg.svh"

module tb;
   logic                sys_clk;
   logic                rst_n;
   logic                wr_stb;
   logic                wr_dir;
   logic                rd_stb;
   logic                ctx;
   logic                rd_valid;
   rzf_pkg::rzf_field_t wr_data;
   rzf_pkg::rzf_field_t rd_data;
   rzf_pkg::rzf_field_t core;
   int                  failures;
   int                  total_checks;

   rzf_reserved_zero_field dut
   (
      .sys_clk_in      (sys_clk),
      .rst_n_in        (rst_n),
      .wr_strobe_in    (wr_stb),
      .wr_direct_in    (wr_dir),
      .wr_data_in      (wr_data),
      .rd_strobe_in    (rd_stb),
      .ctx_reserved_in (ctx),
      .rd_valid_out    (rd_valid),
      .rd_data_out     (rd_data),
      .core_field_out  (core)
   );

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task chk(input rzf_pkg::rzf_field_t seen, input rzf_pkg::rzf_field_t exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one write; core view settles at the taking edge
   task wr(input logic dir, input rzf_pkg::rzf_field_t d,
           input rzf_pkg::rzf_field_t exp_core);
      @(posedge sys_clk);
      wr_stb  <= 1'b1;
      wr_dir  <= dir;
      wr_data <= d;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      #1 chk(core, exp_core);
   endtask : wr

   // one read; answer stands a single cycle, zero otherwise
   task rd(input rzf_pkg::rzf_field_t exp);
      @(posedge sys_clk);
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 chk({7'h00, rd_valid}, 8'h01);
      chk(rd_data, exp);
      @(posedge sys_clk);
      #1 chk({7'h00, rd_valid}, 8'h00);
      chk(rd_data, 8'h00);
   endtask : rd

   task results;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   // ****************************************************************
   // scenarios
   // ****************************************************************
   // the first read rides on the release edge, as early as allowed
   task t_reset;
      rst_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_n  <= 1'b1;
      rd_stb <= 1'b1;
      #1 chk(core, 8'h00);
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 chk({7'h00, rd_valid}, 8'h01);
      chk(rd_data, `RZF_RESET_VAL);
   endtask : t_reset

   // hardwired nibble drops data, stored bits keep it
   task t_direct;
      wr(1'b1, 8'hff, 8'hc0);
      rd(8'hf0);
   endtask : t_direct

   // indirect clears 5:4 only; 7:6 are defined outside the context
   task t_indirect;
      wr(1'b0, 8'hff, 8'hc0);
      rd(8'hc0);
   endtask : t_indirect

   task t_context;
      @(posedge sys_clk);
      ctx <= 1'b1;
      @(posedge sys_clk);
      #1 chk(core, 8'h00);
      wr(1'b1, 8'hff, 8'h00);
      rd(8'hf0);
      wr(1'b0, 8'hff, 8'h00);
      rd(8'h00);
      @(posedge sys_clk);
      ctx <= 1'b0;
      // reserved 5:4 and hardwired 3:0 written as zero
      wr(1'b1, 8'h40, 8'h40);
      @(posedge sys_clk);
      ctx <= 1'b1;
      rd(8'h40);
   endtask : t_context

   // read and write in one cycle: the read sees the old value
   task t_overlap;
      @(posedge sys_clk);
      rd_stb  <= 1'b1;
      wr_stb  <= 1'b1;
      wr_dir  <= 1'b1;
      wr_data <= 8'h10;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      #1 chk(rd_data, 8'h40);
      rd(8'h10);
   endtask : t_overlap

   // direct write, then a read in the very next cycle
   task t_b2b;
      @(posedge sys_clk);
      wr_stb  <= 1'b1;
      wr_dir  <= 1'b1;
      wr_data <= 8'h80;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b1;
      #1 chk(core, 8'h00);
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 chk({7'h00, rd_valid}, 8'h01);
      chk(rd_data, 8'h80);
   endtask : t_b2b

   // ****************************************************************
   // clock, main sequence, watchdog
   // ****************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial
   begin
      wr_stb       = 1'b0;
      wr_dir       = 1'b0;
      wr_data      = 8'h00;
      rd_stb       = 1'b0;
      ctx          = 1'b0;
      failures     = 0;
      total_checks = 0;
      t_reset();
      t_direct();
      t_indirect();
      t_context();
      t_overlap();
      t_b2b();
      // mid-run reset must bring the reset value back
      @(posedge sys_clk);
      t_reset();
      results();
   end

   // the whole run needs under 200 cycles
   initial
   begin
      #20000;
      failures++;
      results();
   end
endmodule : tb
